// ==== shared/port_io_pkg.sv ====
// Contract
// [RL1] First port: 3 bits, latch, per-bit direction.
// [RL2] First port pull-ups enabled per bit.
// [RL3] Second port: 8 bits, latch, per-bit direction.
// [RL4] Second port pull-ups enabled per bit.
// [RL5] Reset puts every bidirectional pin in input.
// [RL6] Third, fourth ports: output only, from latch.
// [RL7] Fifth port: 8 bits, per-bit direction, latch drives.
// [RL8] Fifth port pin levels via level-read register.
// [RL9] Sixth port: 5 bits, like fifth port.
// [RL10] Software zeroes latch before open-drain input use.
// [RL11] Direction registers reset to all ones.
// [RL12] Direction registers written by byte or bit.
// [RL13] Pull-up enable registers reset to zero.
// [RL14] Pull-up bit acts regardless of direction.
// [RL15] Software sets direction one for alternate inputs.
// [RL16] Interrupt pins' level change raises request flag.
// [RL17] Software masks interrupt before output use.
// [RL18] Every port supports bit and byte access.
// [RL19] Output pin read returns latch, latch kept.
// [RL20] Input pin read returns pin level.
// [RL21] Write in input mode updates latch only.
// [RL22] Bit operation rewrites the whole port byte.
// [RL23] Direction one means input, zero means output.
package port_io_pkg;
  localparam logic [15:0] ADDR_PORT0 = 16'hff00;
  localparam logic [15:0] ADDR_PORT2 = 16'hff02;
  localparam logic [15:0] ADDR_PORT3 = 16'hff03;
  localparam logic [15:0] ADDR_PORT4 = 16'hff04;
  localparam logic [15:0] ADDR_PORT5 = 16'hff05;
  localparam logic [15:0] ADDR_PORT6 = 16'hff06;
  localparam logic [15:0] ADDR_FIRST_PORT_DIRECTION = 16'hff20;
  localparam logic [15:0] ADDR_SECOND_PORT_DIRECTION = 16'hff22;
  localparam logic [15:0] ADDR_FIFTH_PORT_LEVEL_READ = 16'hff25;
  localparam logic [15:0] ADDR_SIXTH_PORT_LEVEL_READ = 16'hff26;
  localparam logic [15:0] ADDR_FIRST_PORT_PULLUP_ENABLE = 16'hff30;
  localparam logic [15:0] ADDR_SECOND_PORT_PULLUP_ENABLE = 16'hff32;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam int SYNC_STAGES = 3;
endpackage : port_io_pkg

// ==== rtl/mcu_port_io_block.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcu_port_io_block #(
  parameter int P0_W = 3,
  parameter int P6_W = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_bit_val,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [P0_W-1:0] i_port0_pin,
  output logic [P0_W-1:0] o_port0_out,
  output logic [P0_W-1:0] o_port0_oe,
  output logic [P0_W-1:0] o_port0_pullup,
  input wire logic [7:0] i_port2_pin,
  output logic [7:0] o_port2_out,
  output logic [7:0] o_port2_oe,
  output logic [7:0] o_port2_pullup,
  output logic [7:0] o_port3_out,
  output logic [7:0] o_port4_out,
  input wire logic [7:0] i_port5_pin,
  output logic [7:0] o_port5_out,
  output logic [7:0] o_port5_oe,
  input wire logic [P6_W-1:0] i_port6_pin,
  output logic [P6_W-1:0] o_port6_out,
  output logic [P6_W-1:0] o_port6_oe,
  output logic o_ext_irq_req_a,
  output logic o_ext_irq_req_b
);
  localparam int PIN_W = P0_W + 8 + 8 + P6_W;

  logic [P0_W-1:0] first_port_direction_ff, nxt_first_port_direction;
  logic [7:0] second_port_direction_ff, nxt_second_port_direction;
  logic [P0_W-1:0] first_port_pullup_enable_ff, nxt_first_port_pullup_enable;
  logic [7:0] second_port_pullup_enable_ff, nxt_second_port_pullup_enable;
  logic [P0_W-1:0] lat0_ff, nxt_lat0;
  logic [7:0] lat2_ff, nxt_lat2;
  logic [7:0] lat3_ff, nxt_lat3;
  logic [7:0] lat4_ff, nxt_lat4;
  logic [7:0] lat5_ff, nxt_lat5;
  logic [P6_W-1:0] lat6_ff, nxt_lat6;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_ff, sync2_ff, sync3_ff, lvl_ff, nxt_lvl;
  logic irq_a_ff, irq_b_ff, nxt_irq_a, nxt_irq_b;
  logic [P0_W-1:0] lvl0;
  logic [7:0] lvl2, lvl5;
  logic [P6_W-1:0] lvl6;
  logic [7:0] cur_val, wr_val;

  // Pads a narrow port into a byte; missing bits read as zero.
  function automatic logic [7:0] pad8(input logic [7:0] v, input int w);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      if (k < w)
      begin
        r[k] = v[k];
      end
    end
    return r;
  endfunction : pad8

  // Input pins show the filtered pin level, output pins show the latch.
  function automatic logic [7:0] mode_mux(input logic [7:0] dir, input logic [7:0] pin,
                                          input logic [7:0] lat);
    return (dir & pin) | (~dir & lat);
  endfunction : mode_mux

  assign pin_raw = {i_port6_pin, i_port5_pin, i_port2_pin, i_port0_pin};
  assign lvl0 = lvl_ff[P0_W-1:0];
  assign lvl2 = lvl_ff[P0_W+7:P0_W];
  assign lvl5 = lvl_ff[P0_W+15:P0_W+8];
  assign lvl6 = lvl_ff[PIN_W-1:P0_W+16];

  // A level is accepted only once stages two and three agree, which rejects single-cycle glitches.
  always_comb
  begin
    nxt_lvl = lvl_ff;
    for (int k = 0; k < PIN_W; k++)
    begin
      if (sync2_ff[k] == sync3_ff[k])
      begin
        nxt_lvl[k] = sync3_ff[k];
      end
    end
    nxt_irq_a = nxt_lvl[port_io_pkg::IRQ_A_BIT] != lvl_ff[port_io_pkg::IRQ_A_BIT]; // RL16
    nxt_irq_b = nxt_lvl[port_io_pkg::IRQ_B_BIT] != lvl_ff[port_io_pkg::IRQ_B_BIT]; // RL16
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      lvl_ff <= '0;
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff <= nxt_lvl;
      irq_a_ff <= nxt_irq_a;
      irq_b_ff <= nxt_irq_b;
    end
  end

  // Current byte seen at an address; also the base of a bit operation.
  always_comb
  begin
    case (i_addr)
      port_io_pkg::ADDR_PORT0:
        cur_val = pad8(mode_mux(pad8(8'(first_port_direction_ff), P0_W), pad8(8'(lvl0), P0_W),
                                pad8(8'(lat0_ff), P0_W)), P0_W); // RL19 RL20
      port_io_pkg::ADDR_PORT2:
        cur_val = mode_mux(second_port_direction_ff, lvl2, lat2_ff); // RL19 RL20
      port_io_pkg::ADDR_PORT3: cur_val = lat3_ff;
      port_io_pkg::ADDR_PORT4: cur_val = lat4_ff;
      port_io_pkg::ADDR_PORT5: cur_val = lat5_ff;
      port_io_pkg::ADDR_PORT6: cur_val = pad8(8'(lat6_ff), P6_W);
      port_io_pkg::ADDR_FIFTH_PORT_LEVEL_READ: cur_val = lvl5; // RL8
      port_io_pkg::ADDR_SIXTH_PORT_LEVEL_READ: cur_val = pad8(8'(lvl6), P6_W); // RL9
      port_io_pkg::ADDR_FIRST_PORT_DIRECTION: cur_val = pad8(8'(first_port_direction_ff), P0_W);
      port_io_pkg::ADDR_SECOND_PORT_DIRECTION: cur_val = second_port_direction_ff;
      port_io_pkg::ADDR_FIRST_PORT_PULLUP_ENABLE:
        cur_val = pad8(8'(first_port_pullup_enable_ff), P0_W);
      port_io_pkg::ADDR_SECOND_PORT_PULLUP_ENABLE: cur_val = second_port_pullup_enable_ff;
      default: cur_val = port_io_pkg::UNMAPPED_READ;
    endcase
  end

  // A bit operation rewrites the whole byte, so input pins of the first and second ports pick up their pin level.
  always_comb
  begin
    wr_val = i_wdata;
    if (i_bit_op) // RL18 RL22
    begin
      wr_val = cur_val;
      wr_val[i_bit_sel] = i_bit_val;
    end
  end

  always_comb
  begin
    nxt_first_port_direction = first_port_direction_ff;
    nxt_second_port_direction = second_port_direction_ff;
    nxt_first_port_pullup_enable = first_port_pullup_enable_ff;
    nxt_second_port_pullup_enable = second_port_pullup_enable_ff;
    nxt_lat0 = lat0_ff;
    nxt_lat2 = lat2_ff;
    nxt_lat3 = lat3_ff;
    nxt_lat4 = lat4_ff;
    nxt_lat5 = lat5_ff;
    nxt_lat6 = lat6_ff;
    nxt_rdata = rdata_ff;
    if (i_rd)
    begin
      nxt_rdata = cur_val;
    end
    if (i_wr)
    begin
      case (i_addr)
        port_io_pkg::ADDR_PORT0: nxt_lat0 = wr_val[P0_W-1:0]; // RL1 RL21
        port_io_pkg::ADDR_PORT2: nxt_lat2 = wr_val; // RL3 RL21
        port_io_pkg::ADDR_PORT3: nxt_lat3 = wr_val; // RL6
        port_io_pkg::ADDR_PORT4: nxt_lat4 = wr_val; // RL6
        port_io_pkg::ADDR_PORT5: nxt_lat5 = wr_val; // RL7
        port_io_pkg::ADDR_PORT6: nxt_lat6 = wr_val[P6_W-1:0]; // RL9
        port_io_pkg::ADDR_FIRST_PORT_DIRECTION:
          nxt_first_port_direction = wr_val[P0_W-1:0]; // RL12
        port_io_pkg::ADDR_SECOND_PORT_DIRECTION: nxt_second_port_direction = wr_val; // RL12
        port_io_pkg::ADDR_FIRST_PORT_PULLUP_ENABLE:
          nxt_first_port_pullup_enable = wr_val[P0_W-1:0]; // RL2
        port_io_pkg::ADDR_SECOND_PORT_PULLUP_ENABLE: nxt_second_port_pullup_enable = wr_val; // RL4
        default: nxt_rdata = nxt_rdata;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      first_port_direction_ff <= port_io_pkg::DIRECTION_RESET[P0_W-1:0]; // RL5 RL11
      second_port_direction_ff <= port_io_pkg::DIRECTION_RESET; // RL5 RL11
      first_port_pullup_enable_ff <= port_io_pkg::PULLUP_RESET[P0_W-1:0]; // RL13
      second_port_pullup_enable_ff <= port_io_pkg::PULLUP_RESET; // RL13
      lat0_ff <= port_io_pkg::LATCH_RESET[P0_W-1:0];
      lat2_ff <= port_io_pkg::LATCH_RESET;
      lat3_ff <= port_io_pkg::LATCH_RESET;
      lat4_ff <= port_io_pkg::LATCH_RESET;
      lat5_ff <= port_io_pkg::LATCH_RESET;
      lat6_ff <= port_io_pkg::LATCH_RESET[P6_W-1:0];
      rdata_ff <= port_io_pkg::UNMAPPED_READ;
    end
    else
    begin
      first_port_direction_ff <= nxt_first_port_direction;
      second_port_direction_ff <= nxt_second_port_direction;
      first_port_pullup_enable_ff <= nxt_first_port_pullup_enable;
      second_port_pullup_enable_ff <= nxt_second_port_pullup_enable;
      lat0_ff <= nxt_lat0;
      lat2_ff <= nxt_lat2;
      lat3_ff <= nxt_lat3;
      lat4_ff <= nxt_lat4;
      lat5_ff <= nxt_lat5;
      lat6_ff <= nxt_lat6;
      rdata_ff <= nxt_rdata;
    end
  end

  // The open-drain ports have no direction register of their own, so a zero latch bit is an input.
  // Software still drives them by leaving the latch at one only where it wants a high.
  assign o_rdata = rdata_ff;
  assign o_port0_out = lat0_ff;
  assign o_port0_oe = ~first_port_direction_ff; // RL1 RL23
  assign o_port0_pullup = first_port_pullup_enable_ff; // RL2 RL14
  assign o_port2_out = lat2_ff;
  assign o_port2_oe = ~second_port_direction_ff; // RL3 RL23
  assign o_port2_pullup = second_port_pullup_enable_ff; // RL4 RL14
  assign o_port3_out = lat3_ff; // RL6
  assign o_port4_out = lat4_ff; // RL6
  assign o_port5_out = lat5_ff;
  assign o_port5_oe = lat5_ff; // RL7 RL10
  assign o_port6_out = lat6_ff;
  assign o_port6_oe = lat6_ff; // RL9 RL10
  assign o_ext_irq_req_a = irq_a_ff;
  assign o_ext_irq_req_b = irq_b_ff;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_byte_wr(logic [15:0] a);
    i_wr && !i_bit_op && i_addr == a;
  endsequence

  sequence s_bit_wr(logic [15:0] a);
    i_wr && i_bit_op && i_addr == a;
  endsequence

  a_dir_write: assert property (s_byte_wr(port_io_pkg::ADDR_FIRST_PORT_DIRECTION) |=> // RL12
    o_port0_oe == ~$past(i_wdata[P0_W-1:0]))
    else $error("first port direction write not applied");
  a_pullup_write: assert property (s_byte_wr(port_io_pkg::ADDR_SECOND_PORT_PULLUP_ENABLE) ##1 // RL4
    !i_wr |=> o_port2_pullup == $past(i_wdata, 2))
    else $error("second port pull-up write not applied");
  a_latch_write: assert property (s_byte_wr(port_io_pkg::ADDR_PORT2) |=> // RL21
    o_port2_out == $past(i_wdata))
    else $error("second port latch write lost");
  a_out_read: assert property (i_rd && i_addr == port_io_pkg::ADDR_PORT2 && !i_wr |=> // RL19
    o_rdata == (($past(o_port2_out) & $past(o_port2_oe)) | ($past(lvl2) & ~$past(o_port2_oe))))
    else $error("second port read value wrong");
  a_level_read: assert property (i_rd && i_addr == port_io_pkg::ADDR_FIFTH_PORT_LEVEL_READ |=> // RL8
    o_rdata == $past(lvl5))
    else $error("fifth port level read wrong");
  a_out_only_hold: assert property (!(i_wr && i_addr == port_io_pkg::ADDR_PORT3) |=> // RL6
    $stable(o_port3_out))
    else $error("third port changed without write");
  a_irq_change: assert property ($changed(lvl_ff[port_io_pkg::IRQ_A_BIT]) |-> // RL16
    o_ext_irq_req_a ##1 (o_ext_irq_req_a == $changed(lvl_ff[port_io_pkg::IRQ_A_BIT])))
    else $error("interrupt request not tied to level change");
  a_glitch_reject: assert property ((sync2_ff[0] != sync3_ff[0]) |=> $stable(lvl_ff[0])) // RL20
    else $error("level accepted before stages agreed");
  a_open_drain_drive: assert property (s_byte_wr(port_io_pkg::ADDR_PORT6) |=> // RL9
    o_port6_oe == $past(i_wdata[P6_W-1:0]))
    else $error("sixth port drive wrong");
  a_reset_input: assert property ($rose(i_reset_n) |-> // RL5 RL11
    o_port0_oe == '0 && o_port2_oe == '0 && o_port5_oe == '0 && o_port6_oe == '0)
    else $error("pin left driving after reset");
  a_pullup_reset: assert property ($rose(i_reset_n) |-> // RL13
    o_port0_pullup == '0 && o_port2_pullup == '0)
    else $error("pull-up left connected after reset");
  a_bit_dir: assert property (s_bit_wr(port_io_pkg::ADDR_SECOND_PORT_DIRECTION) |=> // RL12
    o_port2_oe[$past(i_bit_sel)] == !$past(i_bit_val))
    else $error("second port direction bit write not applied");
  a_bit_latch: assert property (s_bit_wr(port_io_pkg::ADDR_PORT2) |=> // RL22
    o_port2_out[$past(i_bit_sel)] == $past(i_bit_val))
    else $error("second port latch bit write not applied");
  a_port0_write: assert property (s_byte_wr(port_io_pkg::ADDR_PORT0) |=> // RL1
    o_port0_out == $past(i_wdata[P0_W-1:0]))
    else $error("first port latch write lost");
  a_port4_hold: assert property (!(i_wr && i_addr == port_io_pkg::ADDR_PORT4) |=> // RL6
    $stable(o_port4_out))
    else $error("fourth port changed without write");
  a_irq_b_change: assert property ($changed(lvl_ff[port_io_pkg::IRQ_B_BIT]) |-> // RL16
    o_ext_irq_req_b ##1 (o_ext_irq_req_b == $changed(lvl_ff[port_io_pkg::IRQ_B_BIT])))
    else $error("second interrupt request not tied to level change");
  a_sixth_level: assert property (i_rd && i_addr == port_io_pkg::ADDR_SIXTH_PORT_LEVEL_READ |=> // RL9
    o_rdata == 8'($past(lvl6)))
    else $error("sixth port level read wrong");
endmodule : mcu_port_io_block
`default_nettype wire

// ==== verif/pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pad_model #(
  parameter int W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_pin
);
  // An undriven pad with no pull-up enabled toggles so that a stale level is never mistaken for data.
  logic [W-1:0] float_ff;
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n) float_ff <= '0;
    else float_ff <= ~float_ff;
  end
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (i_oe[i]) o_pin[i] = i_out[i];
      else if (i_ext_en[i]) o_pin[i] = i_ext[i];
      else if (i_pu[i]) o_pin[i] = 1'b1;
      else o_pin[i] = float_ff[i];
    end
  end
endmodule : pad_model
`default_nettype wire

// ==== verif/test_mcu_port_io_block.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_mcu_port_io_block;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, bop = 1'b0, bval = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [2:0] bsel = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic [2:0] p0, o0, e0, u0, x0 = 3'h0, k0 = 3'h0;
  logic [7:0] p2, o2, e2, u2, x2 = 8'h00, k2 = 8'h00, o3, o4, p5, o5, e5, x5 = 8'h00, k5 = 8'h00;
  logic [4:0] p6, o6, e6, x6 = 5'h00, k6 = 5'h00;
  logic ia, ib;
  int miscompares = 0, n_compared = 0, na, nb;
  initial forever #12.5 clk = ~clk;
  mcu_port_io_block u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr(wr),
    .i_rd(rd), .i_bit_op(bop), .i_bit_sel(bsel), .i_bit_val(bval), .i_wdata(wdata),
    .o_rdata(rdata), .i_port0_pin(p0), .o_port0_out(o0), .o_port0_oe(e0),
    .o_port0_pullup(u0), .i_port2_pin(p2), .o_port2_out(o2), .o_port2_oe(e2),
    .o_port2_pullup(u2), .o_port3_out(o3), .o_port4_out(o4), .i_port5_pin(p5),
    .o_port5_out(o5), .o_port5_oe(e5), .i_port6_pin(p6), .o_port6_out(o6),
    .o_port6_oe(e6), .o_ext_irq_req_a(ia), .o_ext_irq_req_b(ib));
  pad_model #(.W(3)) u_pad0 (.i_clk_sys(clk), .i_reset_n(rst_n), .i_out(o0), .i_oe(e0),
    .i_pu(u0), .i_ext(x0), .i_ext_en(k0), .o_pin(p0));
  pad_model u_pad2 (.i_clk_sys(clk), .i_reset_n(rst_n), .i_out(o2), .i_oe(e2),
    .i_pu(u2), .i_ext(x2), .i_ext_en(k2), .o_pin(p2));
  pad_model u_pad5 (.i_clk_sys(clk), .i_reset_n(rst_n), .i_out(o5), .i_oe(e5),
    .i_pu(8'h00), .i_ext(x5), .i_ext_en(k5), .o_pin(p5));
  pad_model #(.W(5)) u_pad6 (.i_clk_sys(clk), .i_reset_n(rst_n), .i_out(o6), .i_oe(e6),
    .i_pu(5'h00), .i_ext(x6), .i_ext_en(k6), .o_pin(p6));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_op(input logic [15:0] a, input logic [7:0] v, input logic b, input int s);
    addr = a;
    wdata = v;
    bop = b;
    bsel = s[2:0];
    bval = v[0];
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    bop = 1'b0;
    // An idle cycle keeps the strobe from being lowered and raised in one time step.
    @(negedge clk);
  endtask : wr_op
  task automatic rd_op(input logic [15:0] a);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask : rd_op
  task automatic settle();
    // The pin filter needs four cycles; six leaves margin.
    repeat (6) @(negedge clk);
  endtask : settle
  task automatic t_reset();
    chk({e0, e2[4:0]}, 8'h00);
    chk(e5 | {3'h0, e6}, 8'h00);
    rd_op(16'hff22);
    chk(d, 8'hff);
    rd_op(16'hff20);
    chk(d, 8'h07);
    rd_op(16'hff30);
    chk(d, 8'h00);
    rd_op(16'hff32);
    chk(d, 8'h00);
    wr_op(16'hff10, 8'h5a, 1'b0, 0);
    rd_op(16'hff10);
    chk(d, 8'h00);
  endtask : t_reset
  task automatic t_port2();
    k2 = 8'hff;
    x2 = 8'hc3;
    wr_op(16'hff02, 8'h5a, 1'b0, 0);
    chk(o2, 8'h5a);
    chk(e2, 8'h00);
    settle();
    rd_op(16'hff02);
    chk(d, 8'hc3);
    wr_op(16'hff22, 8'h00, 1'b1, 3);
    rd_op(16'hff22);
    chk(d, 8'hf7);
    chk(e2, 8'h08);
    settle();
    rd_op(16'hff02);
    chk(d, 8'hcb);
    wr_op(16'hff02, 8'h00, 1'b1, 3);
    chk(o2, 8'hc3);
  endtask : t_port2
  task automatic t_pullup();
    wr_op(16'hff20, 8'h00, 1'b0, 0);
    wr_op(16'hff30, 8'h05, 1'b0, 0);
    chk({5'h0, u0}, 8'h05);
    chk({5'h0, e0}, 8'h07);
    wr_op(16'hff32, 8'ha5, 1'b0, 0);
    chk(u2, 8'ha5);
    rd_op(16'hff32);
    chk(d, 8'ha5);
  endtask : t_pullup
  task automatic t_outputs();
    wr_op(16'hff03, 8'h3c, 1'b0, 0);
    wr_op(16'hff04, 8'hc3, 1'b0, 0);
    chk(o3, 8'h3c);
    chk(o4, 8'hc3);
    wr_op(16'hff05, 8'h81, 1'b0, 0);
    chk(e5, 8'h81);
    chk(o5, 8'h81);
    k5 = 8'h7e;
    x5 = 8'h24;
    settle();
    rd_op(16'hff25);
    chk(d, 8'ha5);
    wr_op(16'hff06, 8'hff, 1'b0, 0);
    chk({3'h0, o6}, 8'h1f);
    wr_op(16'hff06, 8'h00, 1'b0, 0);
    k6 = 5'h1f;
    x6 = 5'h0a;
    settle();
    rd_op(16'hff26);
    chk(d, 8'h0a);
  endtask : t_outputs
  task automatic t_irq();
    wr_op(16'hff20, 8'hff, 1'b0, 0);
    wr_op(16'hff00, 8'h00, 1'b0, 0);
    k0 = 3'h7;
    x0 = 3'h0;
    settle();
    x0 = 3'h1;
    na = 0;
    nb = 0;
    repeat (10)
    begin
      @(negedge clk);
      na += (ia === 1'b1);
      nb += (ib === 1'b1);
    end
    chk(8'(na), 8'h01);
    chk(8'(nb), 8'h00);
    // Output mode on the second interrupt pin still raises a request.
    wr_op(16'hff20, 8'hfd, 1'b0, 0);
    wr_op(16'hff00, 8'h03, 1'b0, 0);
    chk({5'h0, o0}, 8'h03);
    nb = 0;
    repeat (10)
    begin
      @(negedge clk);
      nb += (ib === 1'b1);
    end
    chk(8'(nb), 8'h01);
  endtask : t_irq
  task automatic complete_run();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_port2();
    t_pullup();
    t_outputs();
    t_irq();
    complete_run();
  end
  initial
  begin
    #(25 * 2000);
    miscompares++;
    complete_run();
  end
endmodule : test_mcu_port_io_block
`default_nettype wire
